// >>> src/babsd_defs.vh
// Constants for the byte ALU, branch and skip decode block.
// Included by the core design file; holds definitions only.
`ifndef BABSD_DEFS_VH
`define BABSD_DEFS_VH

// Opcode fields, upper bits of the 16-bit word
`define BABSD_OP_TESTSKIP_HI 7'h33
`define BABSD_OP_BR_NONZERO_HI 8'hE1
`define BABSD_OP_BR_NOOVF_HI 8'hE5
`define BABSD_OP_XORLIT_HI 8'h0A
`define BABSD_OP_ADDLIT_HI 8'h0F
`define BABSD_OP_ADDFILE_HI 6'h09
// Upper nibble or upper byte of the two-word instructions
`define BABSD_TWO_WORD_HI0 4'hC
`define BABSD_TWO_WORD_HI1 8'hEC
`define BABSD_TWO_WORD_HI2 8'hED
`define BABSD_TWO_WORD_HI3 8'hEE
`define BABSD_TWO_WORD_HI4 8'hEF
// Field positions in the instruction word
`define BABSD_BIT_ACCESS 8
`define BABSD_BIT_DEST 9
// Indexed literal offset limit
`define BABSD_INDEXED_MAX 8'h5F
// Access bank upper half starts at this bank
`define BABSD_ACCESS_HI_BANK 4'hF
// Reset values
`define BABSD_RST_PC 21'h00000
`define BABSD_RST_ACC 8'h00
// Status flag positions: N, OV, Z
`define BABSD_FLAG_N 0
`define BABSD_FLAG_OV 1
`define BABSD_FLAG_Z 2
// Program counter steps, in bytes
`define BABSD_PC_STEP 21'h00002
`define BABSD_PC_STEP_TWO 21'h00004
// Flush cycle counts after a skip or a taken branch
`define BABSD_FLUSH_ONE 2'h1
`define BABSD_FLUSH_TWO 2'h2

`endif

// >>> src/babsd_phase.v
// Four-phase sequencer for one instruction cycle.
// Assumes a single clock; CE low freezes the phase.
`timescale 1ns/1ns
`default_nettype none

module babsd_phase (
    input wire clk,
    input wire rst_n,
    input wire ce,
    output reg [3:0] phase_reg
);
    localparam [3:0] PH_Q1 = 4'h1;
    localparam [3:0] PH_Q2 = 4'h2;
    localparam [3:0] PH_Q3 = 4'h4;
    localparam [3:0] PH_Q4 = 4'h8;

    reg [3:0] phase_next;

    always @* begin
        case (phase_reg)
            PH_Q1: phase_next = PH_Q2;
            PH_Q2: phase_next = PH_Q3;
            PH_Q3: phase_next = PH_Q4;
            PH_Q4: phase_next = PH_Q1;
            default: phase_next = PH_Q1;
        endcase
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            phase_reg <= PH_Q1;
        end else if (ce) begin
            phase_reg <= phase_next;
        end
    end
endmodule

`default_nettype wire

// >>> src/babsd_core.v
// Decode and execute for test-and-skip, relative branches, XOR and adds.
// Assumes fetch presents the prefetched word on INSTR and data file reads
// return combinationally on FILE_RDATA for the address on FILE_ADDR.
`timescale 1ns/1ns
`default_nettype none
`include "babsd_defs.vh"

module babsd_core (
    // Clock, reset, enable
    input wire MCLK,
    input wire RSTN,
    input wire CE,
    // Program fetch
    input wire [15:0] INSTR,
    input wire EXT_SET_EN,
    output reg [20:0] PC,
    output reg FETCH,
    // Data file
    input wire [3:0] BANK_SELECT_REGISTER,
    input wire [7:0] FSR2,
    input wire [7:0] FILE_RDATA,
    output reg [11:0] FILE_ADDR,
    output reg [7:0] FILE_WDATA,
    output reg FILE_WE,
    // Core state
    output reg [7:0] ACC,
    output reg [2:0] STATUS,
    output reg SKIPPING
);
    wire [3:0] phase;
    reg [15:0] ir_reg;
    reg [1:0] flush_cnt_reg;
    reg [7:0] result_reg;
    reg [8:0] sum9;
    reg ov_calc;

    // One-hot phase codes, shared with the sequencer
    localparam [3:0] PH_Q1 = 4'h1;
    localparam [3:0] PH_Q2 = 4'h2;
    localparam [3:0] PH_Q3 = 4'h4;
    localparam [3:0] PH_Q4 = 4'h8;

    babsd_phase u_phase (
        .clk(MCLK),
        .rst_n(RSTN),
        .ce(CE),
        .phase_reg(phase)
    );

    wire is_tst = (ir_reg[15:9] == `BABSD_OP_TESTSKIP_HI);
    wire is_br_nonzero = (ir_reg[15:8] == `BABSD_OP_BR_NONZERO_HI);
    wire is_br_noovf = (ir_reg[15:8] == `BABSD_OP_BR_NOOVF_HI);
    wire is_xor = (ir_reg[15:8] == `BABSD_OP_XORLIT_HI);
    wire is_addl = (ir_reg[15:8] == `BABSD_OP_ADDLIT_HI);
    wire is_addf = (ir_reg[15:10] == `BABSD_OP_ADDFILE_HI);
    wire uses_file = is_tst | is_addf;
    wire acc_bit = ir_reg[`BABSD_BIT_ACCESS];
    wire idle = (flush_cnt_reg != 2'h0);
    wire [7:0] faddr = ir_reg[7:0];

    // Prefetched word two-word check; skip consumes both words
    wire next_two = (INSTR[15:12] == `BABSD_TWO_WORD_HI0) |
        (INSTR[15:8] == `BABSD_TWO_WORD_HI1) |
        (INSTR[15:8] == `BABSD_TWO_WORD_HI2) |
        (INSTR[15:8] == `BABSD_TWO_WORD_HI3) |
        (INSTR[15:8] == `BABSD_TWO_WORD_HI4);

    // Bank and indexed address formation
    reg [11:0] addr_calc;
    always @* begin
        addr_calc = {BANK_SELECT_REGISTER, faddr};
        if (!acc_bit) begin
            if (EXT_SET_EN && faddr <= `BABSD_INDEXED_MAX) begin
                addr_calc = {4'h0, FSR2} + {4'h0, faddr};
            end else if (faddr[7]) begin
                addr_calc = {`BABSD_ACCESS_HI_BANK, faddr};
            end else begin
                addr_calc = {4'h0, faddr};
            end
        end
    end

    // Sign-extended word offset doubled to bytes
    wire [20:0] br_off = {{12{ir_reg[7]}}, ir_reg[7:0], 1'b0};
    wire br_taken = (is_br_nonzero && !STATUS[`BABSD_FLAG_Z]) ||
        (is_br_noovf && !STATUS[`BABSD_FLAG_OV]);

    always @* begin
        sum9 = 9'h000;
        ov_calc = 1'b0;
        if (is_addl) begin
            sum9 = {1'b0, ACC} + {1'b0, ir_reg[7:0]};
            ov_calc = (ACC[7] == ir_reg[7]) && (sum9[7] != ACC[7]);
        end else if (is_addf) begin
            sum9 = {1'b0, ACC} + {1'b0, FILE_RDATA};
            ov_calc = (ACC[7] == FILE_RDATA[7]) && (sum9[7] != ACC[7]);
        end
    end

    always @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            ir_reg <= 16'h0000;
            flush_cnt_reg <= 2'h0;
            result_reg <= 8'h00;
            PC <= `BABSD_RST_PC;
            FETCH <= 1'b0;
            FILE_ADDR <= 12'h000;
            FILE_WDATA <= 8'h00;
            FILE_WE <= 1'b0;
            ACC <= `BABSD_RST_ACC;
            STATUS <= 3'h0;
            SKIPPING <= 1'b0;
        end else if (CE) begin
            FETCH <= 1'b0;
            FILE_WE <= 1'b0;
            case (phase)
                PH_Q1: begin
                    // Decode: latch prefetched word
                    ir_reg <= INSTR;
                    FETCH <= 1'b1;
                    // A flush cycle refetches at the PC that Q4 set;
                    // advancing here would lose the branch target
                    if (!idle) begin
                        PC <= PC + `BABSD_PC_STEP;
                    end
                end
                PH_Q2: begin
                    if (!idle && uses_file) begin
                        FILE_ADDR <= addr_calc;
                    end
                end
                PH_Q3: begin
                    if (!idle) begin
                        result_reg <= is_xor ? (ACC ^ ir_reg[7:0]) : sum9[7:0];
                    end
                end
                PH_Q4: begin
                    if (idle) begin
                        flush_cnt_reg <= flush_cnt_reg - 2'h1;
                        SKIPPING <= (flush_cnt_reg != 2'h1);
                    end else if (is_tst && FILE_RDATA == 8'h00) begin
                        // Step over the discarded words now, since
                        // flush cycles hold the PC still
                        if (next_two) begin
                            flush_cnt_reg <= `BABSD_FLUSH_TWO;
                            PC <= PC + `BABSD_PC_STEP_TWO;
                        end else begin
                            flush_cnt_reg <= `BABSD_FLUSH_ONE;
                            PC <= PC + `BABSD_PC_STEP;
                        end
                        SKIPPING <= 1'b1;
                    end else if (br_taken) begin
                        PC <= PC + br_off;
                        flush_cnt_reg <= `BABSD_FLUSH_ONE;
                        SKIPPING <= 1'b1;
                    end else if (is_xor) begin
                        ACC <= result_reg;
                        STATUS[`BABSD_FLAG_N] <= result_reg[7];
                        STATUS[`BABSD_FLAG_Z] <= (result_reg == 8'h00);
                    end else if (is_addl || (is_addf &&
                        !ir_reg[`BABSD_BIT_DEST])) begin
                        ACC <= sum9[7:0];
                        STATUS[`BABSD_FLAG_N] <= sum9[7];
                        STATUS[`BABSD_FLAG_Z] <= (sum9[7:0] == 8'h00);
                        STATUS[`BABSD_FLAG_OV] <= ov_calc;
                    end else if (is_addf) begin
                        FILE_WDATA <= sum9[7:0];
                        FILE_WE <= 1'b1;
                        STATUS[`BABSD_FLAG_N] <= sum9[7];
                        STATUS[`BABSD_FLAG_Z] <= (sum9[7:0] == 8'h00);
                        STATUS[`BABSD_FLAG_OV] <= ov_calc;
                    end
                end
                default: begin
                    FETCH <= 1'b0;
                end
            endcase
        end
    end
endmodule

`default_nettype wire

// >>> test/babsd_core_assertions.sv
// Port checks for the decode block.
// Assumes four enabled edges per instruction; CE low pauses the checks.
`timescale 1ns/1ns
`default_nettype none
module babsd_core_check (
    // Clock, reset and enable
    input wire MCLK,
    input wire RSTN,
    input wire CE,
    // Fetch side
    input wire [15:0] INSTR,
    input wire [20:0] PC,
    input wire FETCH,
    // Data side
    input wire [3:0] BANK_SELECT_REGISTER,
    input wire [11:0] FILE_ADDR,
    input wire FILE_WE,
    // Core state
    input wire [7:0] ACC,
    input wire [2:0] STATUS,
    input wire SKIPPING
);
    reg [15:0] ir_reg;
    wire go = FETCH && !SKIPPING;
    wire [7:0] lit = ir_reg[7:0];
    wire [20:0] offs = {{12{ir_reg[7]}}, ir_reg[7:0], 1'b0};
    // Frozen edges must not pick up the word behind the held PC
    always @(posedge MCLK) if (CE) ir_reg <= INSTR;
    default clocking @(posedge MCLK); endclocking
    default disable iff (!RSTN || !CE);
    chk_fetch_gap:
        assert property (FETCH |=> !FETCH [*3]) else $error("fetch spacing");
    chk_flush_quiet:
        assert property (SKIPPING |-> !FILE_WE) else $error("flush wrote");
    chk_flush_acc:
        assert property (SKIPPING && $past(SKIPPING) |-> $stable(ACC))
        else $error("flush changed accumulator");
    chk_xor_value:
        assert property (go && ir_reg[15:8] == 8'h0A |->
            ##3 ACC == ($past(ACC, 3) ^ $past(lit, 3))) else $error("xor");
    chk_xor_flags:
        assert property (go && ir_reg[15:8] == 8'h0A |->
            ##3 STATUS[2] == (ACC == 8'h00) && STATUS[0] == ACC[7])
        else $error("xor flags");
    chk_add_value:
        assert property (go && ir_reg[15:8] == 8'h0F |->
            ##3 ACC == $past(ACC, 3) + $past(lit, 3)) else $error("add");
    chk_branch_taken:
        assert property (go && ir_reg[15:8] == 8'hE1 && !STATUS[2] |->
            ##3 PC == $past(PC, 3) + $past(offs, 3) && SKIPPING)
        else $error("branch target");
    chk_branch_held:
        assert property (go && ir_reg[15:8] == 8'hE1 && STATUS[2] |->
            ##3 PC == $past(PC, 3) && !SKIPPING) else $error("branch held");
    chk_bank_addr:
        assert property (go && ir_reg[15:8] == 8'h67 |->
            ##1 FILE_ADDR == {BANK_SELECT_REGISTER, $past(lit)})
        else $error("banked address");
endmodule
bind babsd_core babsd_core_check babsd_core_check_inst (
    .MCLK(MCLK), .RSTN(RSTN), .CE(CE), .INSTR(INSTR), .PC(PC),
    .FETCH(FETCH), .BANK_SELECT_REGISTER(BANK_SELECT_REGISTER),
    .FILE_ADDR(FILE_ADDR), .FILE_WE(FILE_WE), .ACC(ACC),
    .STATUS(STATUS), .SKIPPING(SKIPPING));
`default_nettype wire

// >>> test/babsd_mem_model.sv
// Program store and data file facing the decode block.
// Assumes the bench loads prog while reset is held and file before the boots whose programs read it.
`timescale 1ns/1ns
`default_nettype none
module babsd_mem_model (
    // Fetch
    input wire logic clk,
    input wire logic [20:0] pc,
    output logic [15:0] instr,
    // Data file
    input wire logic [11:0] file_addr,
    input wire logic [7:0] file_wdata,
    input wire logic file_we,
    output logic [7:0] file_rdata
);
    logic [15:0] prog [0:15];
    logic [7:0] file [0:4095];
    assign instr = prog[pc[4:1]];
    assign file_rdata = file[file_addr];
    always @(posedge clk) if (file_we) file[file_addr] <= file_wdata;
endmodule
`default_nettype wire

// >>> test/test_byte_alu_branch_skip_decode.sv
// Self-checking bench for the decode block and its memory model.
// Assumes each instruction spans four enabled edges.
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin errors++; \
    $display("mismatch %s exp %h got %h", n, e, g); end end
module test_byte_alu_branch_skip_decode;
    logic mclk = 0, rstn = 0, ext = 0, ce = 1;
    logic [3:0] bank_sel = 4'h2;
    logic [7:0] fsr2 = 8'h30;
    wire [15:0] ins;
    wire [20:0] pc;
    wire [11:0] fa;
    wire [7:0] frd, fwd, acc;
    wire [2:0] st;
    wire fwe, skip;
    int errors = 0, checks = 0;
    always #5 mclk = ~mclk;
    babsd_core babsd_core_inst (.MCLK(mclk), .RSTN(rstn), .CE(ce),
        .INSTR(ins), .EXT_SET_EN(ext), .PC(pc), .FETCH(),
        .BANK_SELECT_REGISTER(bank_sel), .FSR2(fsr2), .FILE_RDATA(frd),
        .FILE_ADDR(fa), .FILE_WDATA(fwd), .FILE_WE(fwe), .ACC(acc),
        .STATUS(st), .SKIPPING(skip));
    babsd_mem_model babsd_mem_model_inst (.clk(mclk), .pc(pc), .instr(ins),
        .file_addr(fa), .file_wdata(fwd), .file_we(fwe), .file_rdata(frd));
    task automatic boot(input logic [15:0] a, b, c, d, e, f);
        rstn = 0;
        for (int i = 0; i < 16; i++)
            babsd_mem_model_inst.prog[i] = 16'h0000;
        babsd_mem_model_inst.prog[0] = a;
        babsd_mem_model_inst.prog[1] = b;
        babsd_mem_model_inst.prog[2] = c;
        babsd_mem_model_inst.prog[3] = d;
        babsd_mem_model_inst.prog[4] = e;
        babsd_mem_model_inst.prog[5] = f;
        repeat (5) @(posedge mclk);
        #1 rstn = 1;
    endtask
    task automatic run(input int n);
        repeat (4 * n) @(posedge mclk);
        #1;
    endtask
    task t_alu;
        babsd_mem_model_inst.file[12'h020] = 8'hC2;
        boot(16'h0FB5, 16'h0AAF, 16'h0A1A, 16'h0F17, 16'h2620, 16'h2420);
        run(2);
        `CHK("xor", 8'h1A, acc)
        run(1);
        `CHK("zero", 1'b1, st[2])
        run(3);
        `CHK("file", 8'hD9, babsd_mem_model_inst.file[12'h020])
        `CHK("add", 8'hF0, acc)
    endtask
    task t_branch;
        boot(16'h0F01, 16'hE103, 16'h0F40, 16'h0, 16'h0, 16'h0F05);
        run(2);
        `CHK("target", 21'd10, pc)
        run(2);
        `CHK("flushed", 8'h06, acc)
        boot(16'h0F01, 16'hE5FE, 16'h0F40, 16'h0, 16'h0, 16'h0);
        run(2);
        `CHK("back", 21'd0, pc)
        run(2);
        `CHK("loop", 8'h02, acc)
        boot(16'h0A00, 16'hE103, 16'h0F07, 16'h0, 16'h0, 16'h0);
        run(3);
        `CHK("held", 8'h07, acc)
    endtask
    task t_skip;
        babsd_mem_model_inst.file[12'h210] = 8'h00;
        boot(16'h6710, 16'h0F40, 16'h0F03, 16'h0, 16'h0, 16'h0);
        run(1);
        `CHK("bank", 12'h210, fa)
        run(2);
        `CHK("skip", 8'h03, acc)
        boot(16'h6710, 16'hC000, 16'h0F20, 16'h0F03, 16'h0, 16'h0);
        run(4);
        `CHK("skip two", 8'h03, acc)
        boot(16'h6710, 16'hEF00, 16'h0F20, 16'h0F03, 16'h0, 16'h0);
        run(4);
        `CHK("skip long", 8'h03, acc)
        babsd_mem_model_inst.file[12'h210] = 8'h05;
        boot(16'h6710, 16'h0F40, 16'h0, 16'h0, 16'h0, 16'h0);
        run(2);
        `CHK("no skip", 8'h40, acc)
    endtask
    task automatic idx(input logic [7:0] f, input logic [11:0] a);
        boot({8'h66, f}, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0);
        run(1);
        `CHK("index", a, fa)
    endtask
    task t_index;
        ext = 1;
        idx(8'h05, 12'h035);
        idx(8'h5F, 12'h08F);
        idx(8'h60, 12'h060);
        idx(8'h90, 12'hF90);
        ext = 0;
        idx(8'h05, 12'h005);
    endtask
    task t_enable;
        boot(16'h0F01, 16'h0F02, 16'h0, 16'h0, 16'h0, 16'h0);
        run(1);
        ce = 0;
        run(3);
        `CHK("frozen acc", 8'h01, acc)
        `CHK("frozen pc", 21'd2, pc)
        ce = 1;
        run(1);
        `CHK("resumed", 8'h03, acc)
    endtask
    task results;
        $display("errors %0d checks %0d", errors, checks);
        if (errors == 0 && checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        #20000;
        errors++;
        results;
    end
    initial begin
        t_alu;
        t_branch;
        t_skip;
        t_index;
        t_enable;
        results;
    end
endmodule
`default_nettype wire
